// ---- common/rdhs_pkg.sv ----
// Shared constants and types for the reader host-side serial and clock-out block.
// Assumes a single 50 MHz system clock; all pin inputs are asynchronous to it.
package rdhs_pkg;

  // System clock rate.
  localparam longint SYS_CLK_HZ = 64'd50_000_000;

  // Clock-output frequencies, in hertz.
  localparam longint CLK_OUT_F0_HZ = 64'd1_978_000;
  localparam longint CLK_OUT_F1_HZ = 64'd3_955_000;
  localparam longint CLK_OUT_F2_HZ = 64'd7_910_000;
  localparam longint CLK_OUT_F3_HZ = 64'd15_820_000;

  // Width of the phase accumulator of the clock-output synthesiser.
  localparam int NCO_W = 24;

  // Frequency select codes.
  localparam logic [1:0] FSEL_F0 = 2'h0;
  localparam logic [1:0] FSEL_F1 = 2'h1;
  localparam logic [1:0] FSEL_F2 = 2'h2;
  localparam logic [1:0] FSEL_F3 = 2'h3;

  // Seven-bit two-wire addresses for address-select low and high.
  localparam logic [6:0] TWI_ADDR_LO = 7'h28;
  localparam logic [6:0] TWI_ADDR_HI = 7'h6a;

  // Bits per byte and the acknowledge slot count.
  localparam logic [3:0] BIT_LAST = 4'h8;
  localparam logic [3:0] BIT_ACK  = 4'h9;

  // Cycles after reset release before the straps are captured.
  localparam logic [1:0] STRAP_SETTLE = 2'h2;

  // Byte sent when the host reads with nothing pending.
  localparam logic [7:0] IDLE_TWI_BYTE = 8'hff;
  localparam logic [7:0] IDLE_SPI_BYTE = 8'h00;

  // Clock-synthesis configuration register.
  typedef struct packed {
    logic       standby;
    logic       clk_disable;
    logic [1:0] freq_sel;
  } rdhs_cfg_t;

  localparam rdhs_cfg_t CFG_RESET = '{standby: 1'b0, clk_disable: 1'b0, freq_sel: FSEL_F0};

  // Received command byte.
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } rdhs_rx_t;

  // Two-wire slave states.
  typedef enum logic [3:0] {
    TW_IDLE = 4'b0001,
    TW_ADDR = 4'b0010,
    TW_WR   = 4'b0100,
    TW_RD   = 4'b1000
  } rdhs_twi_st_t;

  // Phase increment giving a toggle rate of twice f.
  function automatic logic [NCO_W-1:0] rdhs_nco_inc(input longint f_hz);
    rdhs_nco_inc = NCO_W'(((64'd2 * f_hz) << NCO_W) / SYS_CLK_HZ);
  endfunction : rdhs_nco_inc

endpackage : rdhs_pkg

// ---- src/rdhs_clk_gen.sv ----
// Clock-output synthesiser: a phase accumulator toggling the output pin.
// Assumes configuration inputs come from logic on the same clock.
module rdhs_clk_gen
  import rdhs_pkg::*;
(
  input  wire logic       sys_clk_in,
  input  wire logic       nrst_in,
  input  wire logic [1:0] freq_sel_in,
  input  wire logic       disable_in,
  output logic            clk_out
);

  logic [NCO_W-1:0] acc_r;
  logic [NCO_W:0]   acc_nxt;
  logic [NCO_W-1:0] inc;
  logic             clk_r;

  ////////////////////////////////////////////////////////////////////////////
  // Increment selection.
  always_comb
  begin
    unique case (freq_sel_in)
      FSEL_F0: inc = rdhs_nco_inc(CLK_OUT_F0_HZ); // [RQ6]
      FSEL_F1: inc = rdhs_nco_inc(CLK_OUT_F1_HZ); // [RQ6]
      FSEL_F2: inc = rdhs_nco_inc(CLK_OUT_F2_HZ); // [RQ6]
      FSEL_F3: inc = rdhs_nco_inc(CLK_OUT_F3_HZ); // [RQ6]
    endcase
  end

  assign acc_nxt = {1'b0, acc_r} + {1'b0, inc};

  ////////////////////////////////////////////////////////////////////////////
  // Accumulator and output toggle.
  always_ff @(posedge sys_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      acc_r <= '0;
      clk_r <= 1'b0;
    end
    else if (disable_in)
    begin
      acc_r <= '0; // [RQ7]
      clk_r <= 1'b0; // [RQ7]
    end
    else
    begin
      acc_r <= acc_nxt[NCO_W-1:0];
      if (acc_nxt[NCO_W])
        clk_r <= ~clk_r;
    end
  end

  assign clk_out = clk_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  a_clk_stopped: assert property (@(posedge sys_clk_in) disable iff (!nrst_in) // [RQ7]
    disable_in |=> !clk_out)
    else $error("clock output runs while disabled");

  a_clk_carry: assert property (@(posedge sys_clk_in) disable iff (!nrst_in) // [RQ6]
    (!disable_in && acc_nxt[NCO_W]) |=> (clk_out != $past(clk_out)))
    else $error("clock output missed a toggle");

  c_clk_fast: cover property (@(posedge sys_clk_in) disable iff (!nrst_in)
    (freq_sel_in == FSEL_F3) && $rose(clk_out));

endmodule : rdhs_clk_gen

// ---- src/rdhs_host_if.sv ----
// Host-side serial slave (two-wire or SPI mode 0), handshake status and clock output.
// Assumes all serial and strap pins are asynchronous and the user side is on sys_clk_in.

// Behaviour
// [RQ1] Interface strap low two-wire, high SPI mode 0
// [RQ2] Address strap picks 50/51 or D4/D5 bytes
// [RQ3] Acknowledge only the selected two-wire address
// [RQ4] Host ties address strap low in SPI
// [RQ5] Clock output starts at 1.978 MHz
// [RQ6] Two-bit select picks four clock output rates
// [RQ7] Disable bit stops clock output
// [RQ8] Status high while a byte awaits reading
// [RQ9] Status low when buffer holds nothing unread
// [RQ10] Commands ignored while status is high
// [RQ11] Reset pin low resets whole device
// [RQ12] Host keeps reset pin high in use
// [RQ13] Host serial clock is bit clock always
// [RQ14] Data-in pin input in SPI, open-drain two-wire
// [RQ15] Data-out pin transmits in SPI, unused otherwise
// [RQ16] Slave select frames SPI, unused two-wire
// [RQ17] Config register holds select, disable, standby
// [RQ18] Straps sampled at reset release only
module rdhs_host_if
  import rdhs_pkg::*;
(
  input  wire logic       sys_clk_in,
  input  wire logic       nrst_in,
  input  wire logic       interface_select_pin_in,
  input  wire logic       addr_select_pin_in,
  input  wire logic       serial_clock_pin_in,
  input  wire logic       slave_select_n_pin_in,
  input  wire logic       sdi_pin_in,
  output logic            sdi_pin_out,
  output logic            sdi_pin_oe_out,
  output logic            sdo_pin_out,
  output logic            sdo_pin_oe_out,
  output logic            handshake_status_out,
  output logic            clock_output_pin_out,
  input  wire logic       tx_load_in,
  input  wire logic [7:0] tx_data_in,
  output logic            tx_ready_out,
  output rdhs_rx_t        rx_out,
  input  wire logic       cfg_wr_in,
  input  wire rdhs_cfg_t  cfg_in,
  output rdhs_cfg_t       cfg_out
);

  logic [4:0]   pin_meta_r;
  logic [4:0]   pin_sync_r;
  logic [2:0]   pin_prev_r;
  logic         sck;
  logic         sda;
  logic         ss_n;
  logic         sck_rise;
  logic         sck_fall;
  logic [1:0]   strap_cnt_r;
  logic         strap_done_r;
  logic         mode_spi_r;
  logic         addr_hi_r;
  logic [6:0]   own_addr;
  logic         twi_act;
  logic         spi_act;
  logic         pend_r;
  logic [7:0]   tx_data_r;
  rdhs_cfg_t    cfg_r;
  logic         cfg_seen_r;
  rdhs_rx_t     rx_r;
  rdhs_twi_st_t tw_st_r;
  logic [3:0]   tw_cnt_r;
  logic [7:0]   tw_sh_r;
  logic [7:0]   tw_out_r;
  logic         tw_dir_r;
  logic         tw_mack_r;
  logic         tw_oe_r;
  logic         tw_start;
  logic         tw_stop;
  logic         tw_load;
  logic         tw_rx;
  logic [7:0]   tw_ld;
  logic [3:0]   sp_cnt_r;
  logic [7:0]   sp_sh_r;
  logic [7:0]   sp_out_r;
  logic         sdo_r;
  logic         sp_load;
  logic         sp_rx;
  logic [7:0]   sp_ld;
  logic         take;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and edge detection.
  always_ff @(posedge sys_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      pin_meta_r <= 5'h07;
      pin_sync_r <= 5'h07;
      pin_prev_r <= 3'h7;
    end
    else
    begin
      pin_meta_r <= {interface_select_pin_in, addr_select_pin_in,
                     serial_clock_pin_in, sdi_pin_in, slave_select_n_pin_in};
      pin_sync_r <= pin_meta_r;
      pin_prev_r <= pin_sync_r[2:0];
    end
  end

  assign sck      = pin_sync_r[2];
  assign sda      = pin_sync_r[1];
  assign ss_n     = pin_sync_r[0];
  assign sck_rise = sck & ~pin_prev_r[2]; // [RQ13]
  assign sck_fall = ~sck & pin_prev_r[2]; // [RQ13]

  ////////////////////////////////////////////////////////////////////////////
  // Strap capture after reset release.
  always_ff @(posedge sys_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      strap_cnt_r  <= '0; // [RQ11]
      strap_done_r <= 1'b0;
      mode_spi_r   <= 1'b0;
      addr_hi_r    <= 1'b0;
    end
    else if (!strap_done_r)
    begin
      strap_cnt_r <= strap_cnt_r + 2'h1;
      if (strap_cnt_r == STRAP_SETTLE)
      begin
        strap_done_r <= 1'b1; // [RQ18]
        mode_spi_r   <= pin_sync_r[4]; // [RQ1]
        addr_hi_r    <= pin_sync_r[3]; // [RQ2]
      end
    end
  end

  assign own_addr = addr_hi_r ? TWI_ADDR_HI : TWI_ADDR_LO; // [RQ2]
  assign twi_act  = strap_done_r & ~mode_spi_r; // [RQ1]
  assign spi_act  = strap_done_r & mode_spi_r; // [RQ1]

  ////////////////////////////////////////////////////////////////////////////
  // Outgoing byte holder and handshake status.
  always_ff @(posedge sys_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      pend_r    <= 1'b0;
      tx_data_r <= '0;
    end
    else if (tx_load_in && !pend_r)
    begin
      pend_r    <= 1'b1; // [RQ8]
      tx_data_r <= tx_data_in;
    end
    else if (take)
      pend_r <= 1'b0; // [RQ9]
  end

  assign take                 = pend_r & (tw_load | sp_load);
  assign tx_ready_out         = ~pend_r;
  assign handshake_status_out = pend_r; // [RQ8]

  ////////////////////////////////////////////////////////////////////////////
  // Configuration register.
  always_ff @(posedge sys_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      cfg_r      <= CFG_RESET; // [RQ5]
      cfg_seen_r <= 1'b0;
    end
    else if (cfg_wr_in)
    begin
      cfg_r      <= cfg_in; // [RQ17]
      cfg_seen_r <= 1'b1;
    end
  end

  assign cfg_out = cfg_r;

  rdhs_clk_gen u_clk_gen (
    .sys_clk_in  (sys_clk_in),
    .nrst_in     (nrst_in),
    .freq_sel_in (cfg_r.freq_sel),
    .disable_in  (cfg_r.clk_disable),
    .clk_out     (clock_output_pin_out)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Two-wire slave.
  assign tw_start = twi_act & sck & pin_prev_r[2] & ~sda & pin_prev_r[1];
  assign tw_stop  = twi_act & sck & pin_prev_r[2] & sda & ~pin_prev_r[1];
  assign tw_load  = twi_act & ~tw_start & ~tw_stop & sck_fall & (tw_cnt_r == BIT_ACK) &
                    (((tw_st_r == TW_ADDR) & tw_dir_r) | ((tw_st_r == TW_RD) & tw_mack_r));
  assign tw_rx    = twi_act & ~tw_start & ~tw_stop & sck_fall & (tw_cnt_r == BIT_LAST) &
                    (tw_st_r == TW_WR) & ~pend_r; // [RQ10]
  assign tw_ld    = pend_r ? tx_data_r : IDLE_TWI_BYTE;

  always_ff @(posedge sys_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      tw_st_r   <= TW_IDLE;
      tw_cnt_r  <= '0;
      tw_sh_r   <= '0;
      tw_out_r  <= '0;
      tw_dir_r  <= 1'b0;
      tw_mack_r <= 1'b0;
      tw_oe_r   <= 1'b0;
    end
    else if (!twi_act)
    begin
      tw_st_r <= TW_IDLE;
      tw_oe_r <= 1'b0;
    end
    else if (tw_start)
    begin
      tw_st_r  <= TW_ADDR;
      tw_cnt_r <= '0;
      tw_oe_r  <= 1'b0;
    end
    else if (tw_stop)
    begin
      tw_st_r <= TW_IDLE;
      tw_oe_r <= 1'b0;
    end
    else if (tw_st_r != TW_IDLE && sck_rise)
    begin
      if (tw_cnt_r < BIT_LAST)
        tw_sh_r <= {tw_sh_r[6:0], sda};
      if (tw_cnt_r == BIT_LAST)
        tw_mack_r <= ~sda;
      tw_cnt_r <= tw_cnt_r + 4'h1;
    end
    else if (tw_st_r != TW_IDLE && sck_fall)
    begin
      if (tw_cnt_r == BIT_LAST)
      begin
        tw_oe_r <= 1'b0;
        if (tw_st_r == TW_ADDR)
        begin
          if (tw_sh_r[7:1] == own_addr)
          begin
            tw_oe_r  <= 1'b1; // [RQ3]
            tw_dir_r <= tw_sh_r[0];
          end
          else
            tw_st_r <= TW_IDLE; // [RQ3]
        end
        else if (tw_st_r == TW_WR)
          tw_oe_r <= ~pend_r; // [RQ10]
      end
      else if (tw_cnt_r == BIT_ACK)
      begin
        tw_cnt_r <= '0;
        tw_oe_r  <= 1'b0;
        if (tw_st_r == TW_ADDR)
          tw_st_r <= tw_dir_r ? TW_RD : TW_WR;
        if (tw_st_r == TW_RD && !tw_mack_r)
          tw_st_r <= TW_IDLE;
        if (tw_load)
        begin
          tw_out_r <= {tw_ld[6:0], 1'b1};
          tw_oe_r  <= ~tw_ld[7]; // [RQ14]
        end
      end
      else if (tw_st_r == TW_RD && tw_cnt_r != 4'h0)
      begin
        tw_oe_r  <= ~tw_out_r[7]; // [RQ14]
        tw_out_r <= {tw_out_r[6:0], 1'b1};
      end
    end
  end

  assign sdi_pin_out    = 1'b0;
  assign sdi_pin_oe_out = tw_oe_r & twi_act; // [RQ14]

  ////////////////////////////////////////////////////////////////////////////
  // SPI mode 0 slave.
  assign sp_ld   = pend_r ? tx_data_r : IDLE_SPI_BYTE;
  assign sp_load = spi_act & ~ss_n & ((pin_prev_r[0] & ~sck_rise) |
                   (sck_fall & (sp_cnt_r == BIT_LAST))); // [RQ16]
  assign sp_rx   = spi_act & ~ss_n & ~pin_prev_r[0] & sck_rise &
                   (sp_cnt_r == BIT_LAST - 4'h1) & ~pend_r; // [RQ10]

  always_ff @(posedge sys_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      sp_cnt_r <= '0;
      sp_sh_r  <= '0;
      sp_out_r <= '0;
      sdo_r    <= 1'b0;
    end
    else if (!spi_act || ss_n)
      sp_cnt_r <= '0; // [RQ16]
    else if (sp_load)
    begin
      sp_cnt_r <= '0;
      sp_out_r <= sp_ld;
      sdo_r    <= sp_ld[7]; // [RQ15]
    end
    else if (sck_rise)
    begin
      sp_sh_r  <= {sp_sh_r[6:0], sda}; // [RQ14]
      sp_cnt_r <= sp_cnt_r + 4'h1;
    end
    else if (sck_fall)
    begin
      sdo_r    <= sp_out_r[6]; // [RQ15]
      sp_out_r <= {sp_out_r[6:0], 1'b0};
    end
  end

  assign sdo_pin_out    = sdo_r & spi_act;
  assign sdo_pin_oe_out = spi_act & ~ss_n; // [RQ15]

  ////////////////////////////////////////////////////////////////////////////
  // Received byte to the command side.
  always_ff @(posedge sys_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      rx_r <= '0;
    else
    begin
      rx_r.valid <= tw_rx | sp_rx; // [RQ10]
      if (tw_rx)
        rx_r.data <= tw_sh_r;
      else if (sp_rx)
        rx_r.data <= {sp_sh_r[6:0], sda};
    end
  end

  assign rx_out = rx_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  a_strap_frozen: assert property (@(posedge sys_clk_in) disable iff (!nrst_in) // [RQ18]
    strap_done_r |=> ($stable(mode_spi_r) && $stable(addr_hi_r)))
    else $error("strap changed after capture");

  a_spi_no_drive: assert property (@(posedge sys_clk_in) disable iff (!nrst_in) // [RQ14]
    spi_act |-> !sdi_pin_oe_out)
    else $error("data-in pin driven in SPI mode");

  a_sdo_unused: assert property (@(posedge sys_clk_in) disable iff (!nrst_in) // [RQ15]
    !spi_act |-> (!sdo_pin_oe_out && !sdo_pin_out))
    else $error("data-out pin active outside SPI mode");

  a_addr_nack: assert property (@(posedge sys_clk_in) disable iff (!nrst_in) // [RQ3]
    (twi_act && !tw_start && !tw_stop && sck_fall && tw_st_r == TW_ADDR &&
     tw_cnt_r == BIT_LAST && tw_sh_r[7:1] != own_addr) |=> (tw_st_r == TW_IDLE && !sdi_pin_oe_out))
    else $error("foreign address acknowledged");

  a_addr_choice: assert property (@(posedge sys_clk_in) disable iff (!nrst_in) // [RQ2]
    strap_done_r |-> (own_addr == (addr_hi_r ? 7'h6a : 7'h28)))
    else $error("wrong own address");

  a_status_set: assert property (@(posedge sys_clk_in) disable iff (!nrst_in) // [RQ8]
    (tx_load_in && tx_ready_out) |=> handshake_status_out ##1
    (handshake_status_out || $past(take)))
    else $error("status not raised by pending byte");

  a_status_clear: assert property (@(posedge sys_clk_in) disable iff (!nrst_in) // [RQ9]
    take |=> !handshake_status_out)
    else $error("status high after byte taken");

  a_busy_ignore: assert property (@(posedge sys_clk_in) disable iff (!nrst_in) // [RQ10]
    rx_out.valid |-> $past(!handshake_status_out))
    else $error("command taken while status high");

  a_spi_frame: assert property (@(posedge sys_clk_in) disable iff (!nrst_in) // [RQ16]
    (spi_act && ss_n) |=> (sp_cnt_r == 4'h0 && !rx_out.valid))
    else $error("SPI activity outside frame");

  a_clk_default: assert property (@(posedge sys_clk_in) disable iff (!nrst_in) // [RQ5]
    !cfg_seen_r |-> (cfg_out.freq_sel == FSEL_F0 && !cfg_out.clk_disable))
    else $error("clock output not at default rate");

  a_cfg_store: assert property (@(posedge sys_clk_in) disable iff (!nrst_in) // [RQ17]
    cfg_wr_in |=> (cfg_out == $past(cfg_in)))
    else $error("configuration not stored");

  c_twi_write: cover property (@(posedge sys_clk_in) disable iff (!nrst_in) tw_rx);
  c_twi_read: cover property (@(posedge sys_clk_in) disable iff (!nrst_in) tw_load && pend_r);
  c_spi_byte: cover property (@(posedge sys_clk_in) disable iff (!nrst_in) sp_rx);
  c_clk_off: cover property (@(posedge sys_clk_in) disable iff (!nrst_in) cfg_out.clk_disable);

endmodule : rdhs_host_if

// ---- tb/rdhs_host_model.sv ----
// Behavioural host microcontroller for the serial pins, in SPI mode 0 or two-wire.
// Assumes the bench resolves the open-drain data line and selects the mode with set_mode.
module rdhs_host_model
(
  output logic      serial_clock_out,
  output logic      slave_select_n_out,
  output logic      data_out,
  input  wire logic sdo_in,
  input  wire logic sda_in
);
  timeunit 1ns;
  timeprecision 100ps;

  logic spi_mode_r;

  ////////////////////////////////////////////////////////////////////////////////
  // Idle levels; the select pin is tied low in two-wire mode.
  task automatic set_mode(input logic spi);
    spi_mode_r         = spi;
    serial_clock_out   = ~spi;
    slave_select_n_out = spi;
    data_out           = 1'b1;
  endtask : set_mode

  initial
  begin
    set_mode(1'b1);
  end

  // One bit of 160 ns: data set in the low phase, sampled late in the high phase.
  task automatic bit_io(input logic b, output logic s);
    #40 data_out = b;
    #40 serial_clock_out = 1'b1;
    #76 s = spi_mode_r ? sdo_in : sda_in;
    #4 serial_clock_out = 1'b0;
  endtask : bit_io

  ////////////////////////////////////////////////////////////////////////////////
  // One framed SPI byte; the data line shows no stale value after the frame.
  task automatic spi_xfer(input logic [7:0] tx, output logic [7:0] rx);
    #80 slave_select_n_out = 1'b0;
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(tx[i], rx[i]);
    end
    #80 slave_select_n_out = 1'b1;
    data_out = ~data_out;
  endtask : spi_xfer

  task automatic twi_start;
    #40 data_out = 1'b1;
    #40 serial_clock_out = 1'b1;
    #80 data_out = 1'b0;
    #80 serial_clock_out = 1'b0;
  endtask : twi_start

  task automatic twi_stop;
    #40 data_out = 1'b0;
    #40 serial_clock_out = 1'b1;
    #80 data_out = 1'b1;
    #80;
  endtask : twi_stop

  // Eight bits then the acknowledge slot; a byte of all ones releases the line.
  task automatic twi_byte(input logic [7:0] tx, input logic mack, output logic [7:0] rx,
                          output logic ack);
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(tx[i], rx[i]);
    end
    bit_io(mack, ack);
  endtask : twi_byte

endmodule : rdhs_host_model

// ---- tb/rdhs_host_if_tb_top.sv ----
// Self-checking bench for the host serial pins, handshake status and clock output.
// Assumes the host model in the same folder and the shared package.
module rdhs_host_if_tb_top
  import rdhs_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic       sys_clk_in = 1'b0;
  logic       nrst_in    = 1'b0;
  logic       intf_sel   = 1'b1;
  logic       asel       = 1'b0;
  logic       tx_load    = 1'b0;
  logic [7:0] tx_data    = 8'h00;
  logic       cfg_wr     = 1'b0;
  rdhs_cfg_t  cfg_w      = CFG_RESET;
  logic       scl, ssn, hdat, sdi_o, sdi_oe, sdo, sdo_oe, status, clk_pin, tx_ready;
  rdhs_rx_t   rx;
  rdhs_cfg_t  cfg_r;
  wire logic  sdi_wire = hdat & ~(sdi_oe & ~sdi_o);
  // A released data-out line shows the inverse of its last value.
  wire logic  sdo_wire = sdo_oe ? sdo : ~sdo;
  int         err_total = 0;
  int         compares  = 0;
  int         rx_cnt    = 0;
  int         n;
  int         e;
  logic [7:0] rx_last;
  logic [7:0] rd;
  longint     fhz [4] = '{CLK_OUT_F0_HZ, CLK_OUT_F1_HZ, CLK_OUT_F2_HZ, CLK_OUT_F3_HZ};

  always #10 sys_clk_in = ~sys_clk_in;

  rdhs_host_if dut_u (
    .sys_clk_in(sys_clk_in), .nrst_in(nrst_in), .interface_select_pin_in(intf_sel),
    .addr_select_pin_in(asel), .serial_clock_pin_in(scl), .slave_select_n_pin_in(ssn),
    .sdi_pin_in(sdi_wire), .sdi_pin_out(sdi_o), .sdi_pin_oe_out(sdi_oe), .sdo_pin_out(sdo),
    .sdo_pin_oe_out(sdo_oe), .handshake_status_out(status), .clock_output_pin_out(clk_pin),
    .tx_load_in(tx_load), .tx_data_in(tx_data), .tx_ready_out(tx_ready), .rx_out(rx),
    .cfg_wr_in(cfg_wr), .cfg_in(cfg_w), .cfg_out(cfg_r));

  rdhs_host_model host_u (
    .serial_clock_out(scl), .slave_select_n_out(ssn), .data_out(hdat),
    .sdo_in(sdo_wire), .sda_in(sdi_wire));

  always @(posedge sys_clk_in)
  begin
    if (rx.valid === 1'b1)
    begin
      rx_cnt++;
      rx_last = rx.data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Comparisons and the verdict.
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp)
    begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic chk_bit(input logic got, input logic exp);
    chk({7'h00, got}, {7'h00, exp});
  endtask : chk_bit

  task automatic chk_rng(input int got, input int lo, input int hi);
    compares++;
    if (got < lo || got > hi)
    begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask : chk_rng

  task automatic print_verdict;
    $display("Counts: %0d compares, %0d errors", compares, err_total);
    if (err_total == 0 && compares > 0)
    begin
      $display("All checks passed");
    end
    else
    begin
      $display("Checks failed");
    end
    $finish;
  endtask : print_verdict

  ////////////////////////////////////////////////////////////////////////////////
  // Stimulus tasks.
  task automatic do_reset(input logic i, input logic a);
    @(posedge sys_clk_in);
    #2 nrst_in = 1'b0;
    intf_sel = i;
    asel = a;
    host_u.set_mode(i);
    repeat (4) @(posedge sys_clk_in);
    #2 nrst_in = 1'b1;
    repeat (8) @(posedge sys_clk_in);
    #2;
  endtask : do_reset

  task automatic load_byte(input logic [7:0] d);
    @(posedge sys_clk_in);
    #2 tx_load = 1'b1;
    tx_data = d;
    @(posedge sys_clk_in);
    #2 tx_load = 1'b0;
  endtask : load_byte

  task automatic cfg_write(input rdhs_cfg_t c);
    @(posedge sys_clk_in);
    #2 cfg_wr = 1'b1;
    cfg_w = c;
    @(posedge sys_clk_in);
    #2 cfg_wr = 1'b0;
    chk({4'h0, cfg_r}, {4'h0, c});
  endtask : cfg_write

  task automatic count_rises(input int cyc, output int rises);
    logic prev;
    prev = clk_pin;
    rises = 0;
    repeat (cyc)
    begin
      @(posedge sys_clk_in);
      #2;
      if (clk_pin === 1'b1 && prev === 1'b0) rises++;
      prev = clk_pin;
    end
  endtask : count_rises

  task automatic twi_write(input logic [7:0] a, input logic [7:0] d, input logic ea,
                           input logic ed);
    logic [7:0] r;
    logic       k;
    host_u.twi_start;
    host_u.twi_byte(a, 1'b1, r, k);
    chk_bit(k, ea);
    if (ea === 1'b0)
    begin
      host_u.twi_byte(d, 1'b1, r, k);
      chk_bit(k, ed);
    end
    host_u.twi_stop;
  endtask : twi_write

  task automatic twi_read(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] r;
    logic       k;
    host_u.twi_start;
    host_u.twi_byte(a, 1'b1, r, k);
    chk_bit(k, 1'b0);
    host_u.twi_byte(8'hff, 1'b1, r, k);
    chk(r, exp);
    host_u.twi_stop;
  endtask : twi_read

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial
  begin
    do_reset(1'b1, 1'b0);
    chk({4'h0, cfg_r}, {4'h0, CFG_RESET});
    chk_bit(status, 1'b0);
    chk_bit(tx_ready, 1'b1);
    count_rises(2000, n);
    e = int'(fhz[0] * 2000 / SYS_CLK_HZ);
    chk_rng(n, e - 2, e + 2);
    for (int f = 0; f < 4; f++)
    begin
      cfg_write('{standby: f[0], clk_disable: 1'b0, freq_sel: f[1:0]});
      count_rises(2000, n);
      e = int'(fhz[f] * 2000 / SYS_CLK_HZ);
      chk_rng(n, e - 2, e + 2);
    end
    cfg_write('{standby: 1'b0, clk_disable: 1'b1, freq_sel: FSEL_F3});
    repeat (2) @(posedge sys_clk_in);
    count_rises(500, n);
    chk_rng(n, 0, 0);
    chk_bit(clk_pin, 1'b0);
    host_u.spi_xfer(8'h3c, rd);
    chk(rd, IDLE_SPI_BYTE);
    chk(rx_last, 8'h3c);
    load_byte(8'ha5);
    chk_bit(status, 1'b1);
    chk_bit(tx_ready, 1'b0);
    load_byte(8'h5a);
    host_u.spi_xfer(8'h96, rd);
    chk(rd, 8'ha5);
    chk(rx_last, 8'h96);
    chk_bit(status, 1'b0);
    n = rx_cnt;
    fork
      host_u.spi_xfer(8'h11, rd);
      begin
        #400;
        load_byte(8'hc3);
      end
    join
    chk_rng(rx_cnt, n, n);
    chk(rd, IDLE_SPI_BYTE);
    load_byte(8'h99);
    do_reset(1'b0, 1'b1);
    chk_bit(status, 1'b0);
    chk({4'h0, cfg_r}, {4'h0, CFG_RESET});
    asel = 1'b0;
    twi_write(8'h50, 8'h00, 1'b1, 1'b1);
    twi_write(8'hd0, 8'h00, 1'b1, 1'b1);
    twi_write(8'hd4, 8'h5e, 1'b0, 1'b0);
    chk(rx_last, 8'h5e);
    load_byte(8'h81);
    twi_read(8'hd5, 8'h81);
    chk_bit(status, 1'b0);
    load_byte(8'h42);
    n = rx_cnt;
    twi_write(8'hd4, 8'h33, 1'b0, 1'b1);
    chk_rng(rx_cnt, n, n);
    twi_read(8'hd5, 8'h42);
    chk_bit(sdo_oe, 1'b0);
    chk_bit(sdo, 1'b0);
    chk_bit(sdi_o, 1'b0);
    do_reset(1'b0, 1'b0);
    twi_write(8'h50, 8'ha7, 1'b0, 1'b0);
    chk(rx_last, 8'ha7);
    twi_write(8'hd4, 8'h00, 1'b1, 1'b1);
    twi_read(8'h51, IDLE_TWI_BYTE);
    print_verdict();
  end

  initial
  begin
    #1_000_000;
    err_total++;
    print_verdict();
  end

endmodule : rdhs_host_if_tb_top
